/* File: design/hdlcc_pkg.sv */
// constants shared by both ends of the hdlc controller port
package hdlcc_pkg;
  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'hb0;
  localparam logic [7:0] ADDR_STAT = 8'hb1;
  localparam logic [7:0] ADDR_MASK = 8'hb2;
  localparam logic [7:0] ADDR_RXINFO = 8'hb3;
  localparam logic [7:0] ADDR_RXFIFO = 8'hb4;
  localparam logic [7:0] ADDR_TXINFO = 8'hb5;
  localparam logic [7:0] ADDR_TXFIFO = 8'hb6;
  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  localparam int CTL_RXRST = 6;
  localparam int CTL_IDLE = 5;
  localparam int CTL_TXRST = 4;
  localparam int CTL_ABORT = 3;
  localparam int CTL_EOM = 2;
  localparam int CTL_ZOFF = 1;
  localparam int CTL_CRCOFF = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h7f;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // ----------------------------------------------------------------------
  // status and information fields
  // ----------------------------------------------------------------------
  localparam int ST_RPE = 6;
  localparam int ST_RPS = 5;
  localparam int ST_RX_FIFO_HALF_FULL = 4;
  localparam int ST_RNE = 3;
  localparam int ST_TX_FIFO_HALF_EMPTY = 2;
  localparam int ST_TNF = 1;
  localparam int ST_TX_MESSAGE_DONE = 0;
  localparam logic [7:0] ST_LATCHED = 8'h61;
  localparam int RXI_EMPTY = 0;
  localparam int RXI_OPEN = 1;
  localparam int RXI_CLOSE = 2;
  localparam int RXI_GOOD = 3;
  localparam int RXI_OVR = 4;
  localparam logic [7:0] RXI_LATCHED = 8'h10;
  localparam int TXI_EMPTY = 0;
  localparam int TXI_FULL = 1;
  localparam int TXI_UDR = 2;
  localparam logic [7:0] TXI_LATCHED = 8'h04;
  // ----------------------------------------------------------------------
  // fifo geometry and line patterns
  // ----------------------------------------------------------------------
  localparam int FIFO_AW = 6;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [6:0] FIFO_HALF = 7'h20;
  localparam logic [7:0] PAT_FLAG = 8'h7e;
  localparam logic [7:0] PAT_IDLE = 8'hff;
  localparam logic [7:0] PAT_ABORT = 8'hfe;
  // ----------------------------------------------------------------------
  // host command codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] CMD_WR = 3'h0;
  localparam logic [2:0] CMD_RD = 3'h1;
  localparam logic [2:0] CMD_SREAD = 3'h2;
  localparam logic [2:0] CMD_SPOLL = 3'h3;
  localparam logic [2:0] CMD_TXPUSH = 3'h4;
  localparam logic [2:0] CMD_RXPOP = 3'h5;
endpackage : hdlcc_pkg

/* File: design/hdlcc_if.sv */
// parallel port between host processor and hdlc controller
`timescale 1ns/1ns
interface hdlcc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic int_n;
  modport dev(input addr, input wdata, input wr, input rd,
              output rdata, output int_n);
  modport host(output addr, output wdata, output wr, output rd,
               input rdata, input int_n);
endinterface : hdlcc_if

/* File: design/hdlcc_dev.sv */
// hdlc controller: registers, fifos, transmit byte engine, interrupt
//
// Behaviour
// - 64-byte tx and rx fifos, own ports
// - latched bit sticks until host reads it
// - real-time bits live, no history, write-immune
// - mask one: load current value, clear latch
// - mask zero: readable bit keeps old value
// - host writes mask then reads same register
// - polled host writes back read and mask
// - each status event maskable onto low interrupt
// - interrupt releases once causing bit read
// - rx: wait packet start, then end/level interrupts
// - rx: note flags, pop byte until closing
// - rx: keep packet only when packet good
// - tx: check empty first, then level interrupt
// - tx: write only when not full, eom last
// - tx: wait message done, check underrun
// - idle select: 0 sends 7e, 1 ff
// - tx reset on rising edge of bit
// - abort rising edge: dump fifo, send fe
// - eom bit self-clears after last byte sent
// - zero insert off bit disables stuffing
// - crc off bit disables crc generation
// - end, start, done latched; levels real-time
// - mask register at own address, same bits
`timescale 1ns/1ns
module hdlcc_dev (
  input wire logic i_clk,
  input wire logic i_nrst,
  hdlcc_if.dev bus,
  input wire logic i_tx_slot,
  output logic [7:0] o_tx_byte,
  output logic o_tx_data,
  output logic o_tx_zero_ins_en,
  output logic o_tx_crc_en,
  input wire logic i_rx_vld,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_open,
  input wire logic i_rx_close,
  input wire logic i_rx_good
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [8:0] tmem [0:63];
  logic [10:0] rmem [0:63];
  logic [7:0] ctrl_q, ctrl_d, mask_q, mask_d;
  logic [5:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
  logic [6:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic in_pkt_q, in_pkt_d, abort_q, abort_d;
  logic [7:0] txb_q, txb_d;
  logic txdat_q, txdat_d, zins_q, zins_d, crc_q, crc_d;
  logic [7:0] slat_q, slat_d, sview_q, sview_d, sunrd_q, sunrd_d;
  logic [7:0] rlat_q, rlat_d, rview_q, rview_d;
  logic [7:0] tlat_q, tlat_d, tview_q, tview_d;
  logic [7:0] rdata_q, rdata_d;
  logic intn_q, intn_d;
  logic wr_ctrl, wr_stat, wr_rxi, wr_txi, rd_stat;
  logic txrst, rxrst, abort_go, tpush, tpop, rpush, rpop;
  logic [7:0] sev, rev, tev, slive, rlive, tlive, srd, rrd, trd, pend;
  logic [10:0] rhead;
  logic [8:0] thead;

  // mask one loads current value, mask zero holds the old one
  function automatic [7:0] view_upd(input logic [7:0] view,
                                     input logic [7:0] cur,
                                     input logic [7:0] wm,
                                     input logic [7:0] lmask);
    view_upd = ((view & ~wm) | (cur & wm)) & lmask;
  endfunction : view_upd

  assign rhead = rmem[rrp_q];
  assign thead = tmem[trp_q];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    wr_ctrl = bus.wr && (bus.addr == hdlcc_pkg::ADDR_CTRL);
    wr_stat = bus.wr && (bus.addr == hdlcc_pkg::ADDR_STAT);
    wr_rxi = bus.wr && (bus.addr == hdlcc_pkg::ADDR_RXINFO);
    wr_txi = bus.wr && (bus.addr == hdlcc_pkg::ADDR_TXINFO);
    rd_stat = bus.rd && (bus.addr == hdlcc_pkg::ADDR_STAT);
    // edges seen against the stored bit, so a held one does nothing
    txrst = wr_ctrl && bus.wdata[hdlcc_pkg::CTL_TXRST]
            && !ctrl_q[hdlcc_pkg::CTL_TXRST];
    rxrst = wr_ctrl && bus.wdata[hdlcc_pkg::CTL_RXRST]
            && !ctrl_q[hdlcc_pkg::CTL_RXRST];
    abort_go = wr_ctrl && bus.wdata[hdlcc_pkg::CTL_ABORT]
               && !ctrl_q[hdlcc_pkg::CTL_ABORT];
    sev = 8'h00;
    rev = 8'h00;
    tev = 8'h00;
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = bus.wdata & hdlcc_pkg::CTRL_WMASK;
    end
    mask_d = mask_q;
    if (bus.wr && (bus.addr == hdlcc_pkg::ADDR_MASK)) begin
      mask_d = bus.wdata;
    end
    // transmit fifo and byte engine
    tpush = bus.wr && (bus.addr == hdlcc_pkg::ADDR_TXFIFO)
            && (tcnt_q < hdlcc_pkg::FIFO_DEPTH) && !txrst
            && !abort_go;
    tpop = 1'b0;
    in_pkt_d = in_pkt_q;
    abort_d = abort_q;
    txb_d = txb_q;
    txdat_d = txdat_q;
    if (i_tx_slot) begin
      txdat_d = 1'b0;
      if (abort_q) begin
        txb_d = hdlcc_pkg::PAT_ABORT;
        abort_d = 1'b0;
      end else if (tcnt_q != 7'h00) begin
        tpop = 1'b1;
        txb_d = thead[7:0];
        txdat_d = 1'b1;
        in_pkt_d = !thead[8];
        if (thead[8]) begin
          sev[hdlcc_pkg::ST_TX_MESSAGE_DONE] = 1'b1;
          if (!wr_ctrl) begin
            ctrl_d[hdlcc_pkg::CTL_EOM] = 1'b0;
          end
        end
      end else if (in_pkt_q) begin
        // starved mid-packet: close it with an abort
        txb_d = hdlcc_pkg::PAT_ABORT;
        in_pkt_d = 1'b0;
        tev[hdlcc_pkg::TXI_UDR] = 1'b1;
      end else begin
        txb_d = ctrl_q[hdlcc_pkg::CTL_IDLE] ? hdlcc_pkg::PAT_IDLE
                                            : hdlcc_pkg::PAT_FLAG;
      end
    end
    twp_d = tpush ? twp_q + 6'h01 : twp_q;
    trp_d = tpop ? trp_q + 6'h01 : trp_q;
    tcnt_d = tcnt_q + {6'h00, tpush} - {6'h00, tpop};
    if (txrst || abort_go) begin
      trp_d = twp_q;
      tcnt_d = 7'h00;
      in_pkt_d = 1'b0;
      abort_d = abort_go;
    end
    zins_d = !ctrl_q[hdlcc_pkg::CTL_ZOFF];
    crc_d = !ctrl_q[hdlcc_pkg::CTL_CRCOFF];
    // receive fifo
    rpush = i_rx_vld && (rcnt_q < hdlcc_pkg::FIFO_DEPTH) && !rxrst;
    rpop = bus.rd && (bus.addr == hdlcc_pkg::ADDR_RXFIFO)
           && (rcnt_q != 7'h00);
    if (i_rx_vld && !rxrst) begin
      sev[hdlcc_pkg::ST_RPS] = i_rx_open;
      sev[hdlcc_pkg::ST_RPE] = i_rx_close || !rpush;
      rev[hdlcc_pkg::RXI_OVR] = !rpush;
    end
    rwp_d = rpush ? rwp_q + 6'h01 : rwp_q;
    rrp_d = rpop ? rrp_q + 6'h01 : rrp_q;
    rcnt_d = rcnt_q + {6'h00, rpush} - {6'h00, rpop};
    if (rxrst) begin
      rrp_d = rwp_q;
      rcnt_d = 7'h00;
    end
    // live levels never pass through the latch logic
    slive = 8'h00;
    slive[hdlcc_pkg::ST_RX_FIFO_HALF_FULL] = rcnt_q > hdlcc_pkg::FIFO_HALF;
    slive[hdlcc_pkg::ST_RNE] = rcnt_q != 7'h00;
    slive[hdlcc_pkg::ST_TX_FIFO_HALF_EMPTY] = tcnt_q < hdlcc_pkg::FIFO_HALF;
    slive[hdlcc_pkg::ST_TNF] = tcnt_q < hdlcc_pkg::FIFO_DEPTH;
    rlive = 8'h00;
    rlive[hdlcc_pkg::RXI_EMPTY] = rcnt_q == 7'h00;
    if (rcnt_q != 7'h00) begin
      rlive[hdlcc_pkg::RXI_OPEN] = rhead[8];
      rlive[hdlcc_pkg::RXI_CLOSE] = rhead[9];
      rlive[hdlcc_pkg::RXI_GOOD] = rhead[10];
    end
    tlive = 8'h00;
    tlive[hdlcc_pkg::TXI_EMPTY] = tcnt_q == 7'h00;
    tlive[hdlcc_pkg::TXI_FULL] = tcnt_q == hdlcc_pkg::FIFO_DEPTH;
    // set wins over a clearing write in the same cycle
    slat_d = (slat_q & ~(wr_stat ? bus.wdata : 8'h00)) | sev;
    rlat_d = (rlat_q & ~(wr_rxi ? bus.wdata : 8'h00)) | rev;
    tlat_d = (tlat_q & ~(wr_txi ? bus.wdata : 8'h00)) | tev;
    sview_d = wr_stat ? view_upd(sview_q, slat_q | sev, bus.wdata,
                                 hdlcc_pkg::ST_LATCHED) : sview_q;
    rview_d = wr_rxi ? view_upd(rview_q, rlat_q | rev, bus.wdata,
                                hdlcc_pkg::RXI_LATCHED) : rview_q;
    tview_d = wr_txi ? view_upd(tview_q, tlat_q | tev, bus.wdata,
                                hdlcc_pkg::TXI_LATCHED) : tview_q;
    srd = sview_q | (slive & ~hdlcc_pkg::ST_LATCHED);
    rrd = rview_q | (rlive & ~hdlcc_pkg::RXI_LATCHED);
    trd = tview_q | (tlive & ~hdlcc_pkg::TXI_LATCHED);
    // loaded-but-unread bits keep the interrupt asserted until read
    sunrd_d = sunrd_q;
    if (rd_stat) begin
      sunrd_d = 8'h00;
    end
    if (wr_stat) begin
      sunrd_d = sunrd_d | (bus.wdata & (slat_q | sev)
                & hdlcc_pkg::ST_LATCHED);
    end
    pend = (((slat_q | sunrd_q) & hdlcc_pkg::ST_LATCHED)
           | (slive & ~hdlcc_pkg::ST_LATCHED)) & mask_q;
    intn_d = !(|pend);
    // read data, registered one cycle after the strobe
    rdata_d = rdata_q;
    if (bus.rd) begin
      if (bus.addr == hdlcc_pkg::ADDR_CTRL) begin
        rdata_d = ctrl_q;
      end else if (bus.addr == hdlcc_pkg::ADDR_STAT) begin
        rdata_d = srd;
      end else if (bus.addr == hdlcc_pkg::ADDR_MASK) begin
        rdata_d = mask_q;
      end else if (bus.addr == hdlcc_pkg::ADDR_RXINFO) begin
        rdata_d = rrd;
      end else if (bus.addr == hdlcc_pkg::ADDR_RXFIFO) begin
        rdata_d = (rcnt_q != 7'h00) ? rhead[7:0] : 8'h00;
      end else if (bus.addr == hdlcc_pkg::ADDR_TXINFO) begin
        rdata_d = trd;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (tpush) begin
      tmem[twp_q] <= {ctrl_q[hdlcc_pkg::CTL_EOM], bus.wdata};
    end
    if (rpush) begin
      rmem[rwp_q] <= {i_rx_good, i_rx_close, i_rx_open, i_rx_byte};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {ctrl_q, mask_q} <= {hdlcc_pkg::CTRL_RESET, hdlcc_pkg::MASK_RESET};
      {twp_q, trp_q, rwp_q, rrp_q} <= 24'h000000;
      {tcnt_q, rcnt_q} <= 14'h0000;
      {in_pkt_q, abort_q} <= 2'h0;
      txb_q <= hdlcc_pkg::PAT_FLAG;
      {txdat_q, zins_q, crc_q} <= 3'h3;
      {slat_q, sview_q, sunrd_q} <= 24'h000000;
      {rlat_q, rview_q, tlat_q, tview_q} <= 32'h00000000;
      {rdata_q, intn_q} <= 9'h001;
    end else begin
      {ctrl_q, mask_q} <= {ctrl_d, mask_d};
      {twp_q, trp_q, rwp_q, rrp_q} <= {twp_d, trp_d, rwp_d, rrp_d};
      {tcnt_q, rcnt_q} <= {tcnt_d, rcnt_d};
      {in_pkt_q, abort_q} <= {in_pkt_d, abort_d};
      txb_q <= txb_d;
      {txdat_q, zins_q, crc_q} <= {txdat_d, zins_d, crc_d};
      {slat_q, sview_q, sunrd_q} <= {slat_d, sview_d, sunrd_d};
      {rlat_q, rview_q, tlat_q, tview_q} <= {rlat_d, rview_d, tlat_d, tview_d};
      {rdata_q, intn_q} <= {rdata_d, intn_d};
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.int_n = intn_q;
  assign o_tx_byte = txb_q;
  assign o_tx_data = txdat_q;
  assign o_tx_zero_ins_en = zins_q;
  assign o_tx_crc_en = crc_q;
endmodule : hdlcc_dev

/* File: design/hdlcc_host.sv */
// host end: turns user commands into parallel port cycles
`timescale 1ns/1ns
module hdlcc_host (
  input wire logic i_clk,
  input wire logic i_nrst,
  hdlcc_if.host bus,
  input wire logic i_cmd_vld,
  input wire logic [2:0] i_cmd_op,
  input wire logic [7:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_cmd_last,
  output logic o_cmd_rdy,
  output logic o_rsp_vld,
  output logic [7:0] o_rsp_data,
  output logic [3:0] o_rsp_flags,
  output logic o_irq
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_MWR = 4'h1, S_MRD = 4'h2, S_MCAP = 4'h3,
    S_PWB = 4'h4, S_EOM = 4'h5, S_DWR = 4'h6, S_FRD = 4'h7,
    S_FCAP = 4'h8, S_RESP = 4'h9
  } hdlcc_hst_t;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  hdlcc_hst_t st_q, st_d;
  logic [2:0] op_q, op_d;
  logic [7:0] ra_q, ra_d, dat_q, dat_d, msk_q, msk_d, shadow_q, shadow_d;
  logic last_q, last_d;
  logic [7:0] rval_q, rval_d, addr_q, addr_d, wdata_q, wdata_d;
  logic [3:0] flg_q, flg_d;
  logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d, rsp_q, rsp_d, irq_q, irq_d;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    ra_d = ra_q;
    dat_d = dat_q;
    msk_d = msk_q;
    last_d = last_q;
    rval_d = rval_q;
    flg_d = flg_q;
    shadow_d = shadow_q;
    case (st_q)
      S_IDLE: begin
        if (i_cmd_vld) begin
          op_d = i_cmd_op;
          ra_d = i_cmd_addr;
          dat_d = i_cmd_data;
          msk_d = i_cmd_data;
          last_d = i_cmd_last;
          flg_d = 4'h0;
          if (i_cmd_op == hdlcc_pkg::CMD_TXPUSH) begin
            ra_d = hdlcc_pkg::ADDR_TXINFO;
            msk_d = 8'h00;
          end else if (i_cmd_op == hdlcc_pkg::CMD_RXPOP) begin
            ra_d = hdlcc_pkg::ADDR_RXINFO;
            msk_d = 8'h00;
          end
          if (i_cmd_op == hdlcc_pkg::CMD_WR) begin
            st_d = S_DWR;
          end else if (i_cmd_op == hdlcc_pkg::CMD_RD) begin
            st_d = S_MRD;
          end else begin
            st_d = S_MWR;
          end
        end
      end
      S_MWR: st_d = S_MRD;
      S_MRD: st_d = S_MCAP;
      S_MCAP: begin
        rval_d = bus.rdata;
        st_d = S_RESP;
        if (op_q == hdlcc_pkg::CMD_SPOLL) begin
          st_d = S_PWB;
        end else if (op_q == hdlcc_pkg::CMD_TXPUSH) begin
          // a full fifo refuses the byte; caller waits for an irq
          if (bus.rdata[hdlcc_pkg::TXI_FULL]) begin
            flg_d[0] = 1'b1;
          end else begin
            st_d = last_q ? S_EOM : S_DWR;
          end
        end else if (op_q == hdlcc_pkg::CMD_RXPOP) begin
          flg_d = {bus.rdata[hdlcc_pkg::RXI_GOOD],
                   bus.rdata[hdlcc_pkg::RXI_CLOSE],
                   bus.rdata[hdlcc_pkg::RXI_OPEN],
                   bus.rdata[hdlcc_pkg::RXI_EMPTY]};
          if (!bus.rdata[hdlcc_pkg::RXI_EMPTY]) begin
            st_d = S_FRD;
          end
        end
      end
      S_PWB: st_d = S_RESP;
      S_EOM: st_d = S_DWR;
      S_DWR: begin
        if ((op_q == hdlcc_pkg::CMD_WR)
            && (ra_q == hdlcc_pkg::ADDR_CTRL)) begin
          shadow_d = dat_q;
        end
        st_d = S_RESP;
      end
      S_FRD: st_d = S_FCAP;
      S_FCAP: begin
        rval_d = bus.rdata;
        st_d = S_RESP;
      end
      S_RESP: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    // bus cycle for the state being entered
    wr_d = 1'b0;
    rd_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    case (st_d)
      S_MWR: begin
        wr_d = 1'b1;
        addr_d = ra_d;
        wdata_d = msk_d;
      end
      S_MRD: begin
        rd_d = 1'b1;
        addr_d = ra_d;
      end
      S_PWB: begin
        wr_d = 1'b1;
        wdata_d = bus.rdata & msk_q;
      end
      S_EOM: begin
        wr_d = 1'b1;
        addr_d = hdlcc_pkg::ADDR_CTRL;
        wdata_d = shadow_q | (8'h01 << hdlcc_pkg::CTL_EOM);
      end
      S_DWR: begin
        wr_d = 1'b1;
        addr_d = (op_d == hdlcc_pkg::CMD_WR) ? ra_d
                                             : hdlcc_pkg::ADDR_TXFIFO;
        wdata_d = dat_d;
      end
      S_FRD: begin
        rd_d = 1'b1;
        addr_d = hdlcc_pkg::ADDR_RXFIFO;
      end
      default: begin
        wr_d = 1'b0;
      end
    endcase
    rdy_d = st_d == S_IDLE;
    rsp_d = st_d == S_RESP;
    // level interrupt; caller picks which events to unmask
    irq_d = !bus.int_n;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= S_IDLE;
      op_q <= hdlcc_pkg::CMD_WR;
      ra_q <= 8'h00;
      dat_q <= 8'h00;
      msk_q <= 8'h00;
      shadow_q <= hdlcc_pkg::CTRL_RESET;
      last_q <= 1'b0;
      rval_q <= 8'h00;
      flg_q <= 4'h0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b0;
      rsp_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      ra_q <= ra_d;
      dat_q <= dat_d;
      msk_q <= msk_d;
      shadow_q <= shadow_d;
      last_q <= last_d;
      rval_q <= rval_d;
      flg_q <= flg_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      rsp_q <= rsp_d;
      irq_q <= irq_d;
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign o_cmd_rdy = rdy_q;
  assign o_rsp_vld = rsp_q;
  assign o_rsp_data = rval_q;
  assign o_rsp_flags = flg_q;
  assign o_irq = irq_q;
endmodule : hdlcc_host

/* File: tb/hdlcc_checker.sv */
// concurrent checks on the host to controller parallel port
`timescale 1ns/1ns
module hdlcc_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic int_n
);
  // ------------------------------------------------------------------
  // shadows of host writes; eom bit left out, it self-clears
  // ------------------------------------------------------------------
  logic [7:0] ctl_q, ctl_d, msk_q, msk_d;
  always_comb begin
    ctl_d = ctl_q;
    msk_d = msk_q;
    if (wr && addr == hdlcc_pkg::ADDR_CTRL) ctl_d = wdata;
    if (wr && addr == hdlcc_pkg::ADDR_MASK) msk_d = wdata;
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_q <= hdlcc_pkg::CTRL_RESET;
      msk_q <= hdlcc_pkg::MASK_RESET;
    end else begin
      ctl_q <= ctl_d;
      msk_q <= msk_d;
    end
  end
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_txfifo_rd_zero: assert property (
    rd && addr == hdlcc_pkg::ADDR_TXFIFO |=> rdata == 8'h00)
    else $error("tx fifo port read not zero");
  a_ctrl_readback: assert property (
    rd && addr == hdlcc_pkg::ADDR_CTRL |=> (rdata & 8'hfb) == (ctl_q & 8'h7b))
    else $error("control readback wrong");
  a_stat_top_zero: assert property (
    rd && addr == hdlcc_pkg::ADDR_STAT |=> rdata[7] == 1'b0)
    else $error("status top bit set");
  a_mask_readback: assert property (
    rd && addr == hdlcc_pkg::ADDR_MASK |=> rdata[6:0] == msk_q[6:0])
    else $error("mask readback wrong");
  a_irq_masked_off: assert property (
    (msk_q == 8'h00) [*3] |-> int_n)
    else $error("interrupt low with all masked");
  a_rd_single: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  a_wr_rd_apart: assert property (!(wr && rd))
    else $error("write and read in one cycle");
  c_ctrl_wr: cover property (wr && addr == hdlcc_pkg::ADDR_CTRL);
  c_irq_fell: cover property ($fell(int_n));
  c_rx_pop: cover property (rd && addr == hdlcc_pkg::ADDR_RXFIFO);
endmodule : hdlcc_checker

/* File: tb/tb_top.sv */
// self-checking bench: host end and controller end back to back
`timescale 1ns/1ns
module tb_top;
  logic i_clk, i_nrst, i_tx_slot, i_rx_vld, i_rx_open, i_rx_close;
  logic i_rx_good, i_cmd_vld, i_cmd_last, o_cmd_rdy, o_rsp_vld, o_irq;
  logic o_tx_data, o_tx_zero_ins_en, o_tx_crc_en;
  logic [7:0] i_rx_byte, i_cmd_addr, i_cmd_data, o_rsp_data, o_tx_byte;
  logic [2:0] i_cmd_op;
  logic [3:0] o_rsp_flags;
  int n_fail = 0;
  int total_checks = 0;
  hdlcc_if hdlcc_if_inst();
  hdlcc_dev hdlcc_dev_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .bus(hdlcc_if_inst), .i_tx_slot(i_tx_slot), .o_tx_byte(o_tx_byte),
    .o_tx_data(o_tx_data), .o_tx_zero_ins_en(o_tx_zero_ins_en),
    .o_tx_crc_en(o_tx_crc_en), .i_rx_vld(i_rx_vld), .i_rx_byte(i_rx_byte),
    .i_rx_open(i_rx_open), .i_rx_close(i_rx_close), .i_rx_good(i_rx_good));
  hdlcc_host hdlcc_host_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .bus(hdlcc_if_inst), .i_cmd_vld(i_cmd_vld), .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data), .i_cmd_last(i_cmd_last),
    .o_cmd_rdy(o_cmd_rdy), .o_rsp_vld(o_rsp_vld), .o_rsp_data(o_rsp_data),
    .o_rsp_flags(o_rsp_flags), .o_irq(o_irq));
  hdlcc_checker hdlcc_checker_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .addr(hdlcc_if_inst.addr), .wdata(hdlcc_if_inst.wdata),
    .rdata(hdlcc_if_inst.rdata), .wr(hdlcc_if_inst.wr),
    .rd(hdlcc_if_inst.rd), .int_n(hdlcc_if_inst.int_n));
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cmd(input logic [2:0] op, input logic [7:0] a, d,
                     input logic l = 1'b0);
    int k;
    k = 0;
    while (o_cmd_rdy !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    {i_cmd_vld, i_cmd_op, i_cmd_addr, i_cmd_data, i_cmd_last} =
      {1'b1, op, a, d, l};
    @(negedge i_clk);
    i_cmd_vld = 1'b0;
    k = 0;
    while (o_rsp_vld !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 20) chk(8'h01, 8'h00);
  endtask : cmd
  // slot sampled at edge k, byte shows right after edge k; checked after edge k+1
  task automatic slot(input logic [7:0] e, input logic d);
    i_tx_slot = 1'b1;
    @(negedge i_clk);
    i_tx_slot = 1'b0;
    @(negedge i_clk);
    chk(o_tx_byte, e);
    chk({7'h00, o_tx_data}, {7'h00, d});
  endtask : slot
  task automatic rx(input logic [7:0] b, input logic [2:0] f);
    {i_rx_vld, i_rx_byte, i_rx_good, i_rx_close, i_rx_open} = {1'b1, b, f};
    @(negedge i_clk);
    i_rx_vld = 1'b0;
  endtask : rx
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_ctrl;
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h23);
    cmd(hdlcc_pkg::CMD_RD, hdlcc_pkg::ADDR_CTRL, 8'h00);
    chk(o_rsp_data, 8'h23);
    chk({6'h00, o_tx_zero_ins_en, o_tx_crc_en}, 8'h00);
    slot(hdlcc_pkg::PAT_IDLE, 1'b0);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h00);
    // enables follow the control register one cycle late
    @(negedge i_clk);
    chk({6'h00, o_tx_zero_ins_en, o_tx_crc_en}, 8'h03);
    slot(hdlcc_pkg::PAT_FLAG, 1'b0);
  endtask : t_ctrl
  task automatic t_tx;
    cmd(hdlcc_pkg::CMD_TXPUSH, 8'h00, 8'ha5);
    cmd(hdlcc_pkg::CMD_TXPUSH, 8'h00, 8'h3c, 1'b1);
    slot(8'ha5, 1'b1);
    slot(8'h3c, 1'b1);
    cmd(hdlcc_pkg::CMD_RD, hdlcc_pkg::ADDR_CTRL, 8'h00);
    chk(o_rsp_data & 8'h04, 8'h00);
    cmd(hdlcc_pkg::CMD_SREAD, hdlcc_pkg::ADDR_STAT, 8'h01);
    chk(o_rsp_data & 8'h07, 8'h07);
    cmd(hdlcc_pkg::CMD_SPOLL, hdlcc_pkg::ADDR_STAT, 8'h01);
    chk(o_rsp_data & 8'h01, 8'h00);
    slot(hdlcc_pkg::PAT_FLAG, 1'b0);
    cmd(hdlcc_pkg::CMD_TXPUSH, 8'h00, 8'h96);
    slot(8'h96, 1'b1);
    slot(hdlcc_pkg::PAT_ABORT, 1'b0);
    cmd(hdlcc_pkg::CMD_SREAD, hdlcc_pkg::ADDR_TXINFO, 8'h04);
    chk(o_rsp_data & 8'h04, 8'h04);
  endtask : t_tx
  task automatic t_rx;
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_MASK, 8'h20);
    rx(8'h5a, 3'b001);
    repeat (4) @(negedge i_clk);
    chk({7'h00, o_irq}, 8'h01);
    cmd(hdlcc_pkg::CMD_SREAD, hdlcc_pkg::ADDR_STAT, 8'h20);
    chk(o_rsp_data & 8'h28, 8'h28);
    repeat (3) @(negedge i_clk);
    chk({7'h00, o_irq}, 8'h00);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_MASK, 8'h00);
    rx(8'hc3, 3'b110);
    cmd(hdlcc_pkg::CMD_RXPOP, 8'h00, 8'h00);
    chk(o_rsp_data, 8'h5a);
    chk({4'h0, o_rsp_flags}, 8'h02);
    cmd(hdlcc_pkg::CMD_RXPOP, 8'h00, 8'h00);
    chk(o_rsp_data, 8'hc3);
    chk({4'h0, o_rsp_flags}, 8'h0c);
    cmd(hdlcc_pkg::CMD_SREAD, hdlcc_pkg::ADDR_STAT, 8'h00);
    chk(o_rsp_data & 8'h28, 8'h20);
    rx(8'h77, 3'b001);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h40);
    cmd(hdlcc_pkg::CMD_RXPOP, 8'h00, 8'h00);
    chk({7'h00, o_rsp_flags[0]}, 8'h01);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h00);
  endtask : t_rx
  task automatic t_full;
    for (int i = 0; i < 65; i++) begin
      cmd(hdlcc_pkg::CMD_TXPUSH, 8'h00, 8'(i));
      chk({7'h00, o_rsp_flags[0]}, {7'h00, i == 64});
    end
    cmd(hdlcc_pkg::CMD_SREAD, hdlcc_pkg::ADDR_STAT, 8'h00);
    chk(o_rsp_data & 8'h06, 8'h00);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h10);
    cmd(hdlcc_pkg::CMD_SREAD, hdlcc_pkg::ADDR_TXINFO, 8'h00);
    chk(o_rsp_data & 8'h01, 8'h01);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h00);
    cmd(hdlcc_pkg::CMD_TXPUSH, 8'h00, 8'h11);
    cmd(hdlcc_pkg::CMD_WR, hdlcc_pkg::ADDR_CTRL, 8'h08);
    slot(hdlcc_pkg::PAT_ABORT, 1'b0);
    slot(hdlcc_pkg::PAT_FLAG, 1'b0);
  endtask : t_full
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    {i_nrst, i_tx_slot, i_rx_vld, i_rx_open, i_rx_close, i_rx_good} = 6'h00;
    {i_cmd_vld, i_cmd_last, i_cmd_op} = 5'h00;
    {i_rx_byte, i_cmd_addr, i_cmd_data} = 24'h000000;
    repeat (16) @(negedge i_clk);
    i_nrst = 1'b1;
    t_ctrl();
    t_tx();
    t_rx();
    t_full();
    wrap_up();
  end
  // whole run is near 550 cycles; allow over thirty-five times that
  initial begin
    #(50 * 20000);
    n_fail++;
    wrap_up();
  end
endmodule : tb_top
